// ### smbsc_top.v
`timescale 1ns/1ps
`include "smbsc_defs.vh"
module smbsc_top (
  input wire clk_i,               // System clock, 100 MHz
  input wire reset_i,             // Async reset, active high
  input wire hsel_i,              // AHB select
  input wire [31:0] haddr_i,      // AHB address
  input wire [1:0] htrans_i,      // AHB transfer type
  input wire hwrite_i,            // AHB write
  input wire [2:0] hsize_i,       // AHB size
  input wire [31:0] hwdata_i,     // AHB write data
  input wire hready_i,            // AHB bus ready
  output reg [31:0] hrdata_o,     // AHB read data
  output reg hreadyout_o,         // AHB slave ready
  output reg hresp_o,             // AHB response, always OKAY
  input wire scl_i,               // Clock line level
  output reg scl_o,               // Clock line drive value
  output reg scl_oe_o,            // Clock line pulled low
  input wire sda_i,               // Data line level
  output reg sda_o,               // Data line drive value
  output reg sda_oe_o,            // Data line pulled low
  input wire timer0_ovf_i,        // Timer 0 overflow
  input wire timer1_ovf_i,        // Timer 1 overflow
  input wire timer2h_ovf_i,       // Timer 2 high-byte overflow
  input wire timer2l_ovf_i,       // Timer 2 low-byte overflow
  input wire [1:0] mst_phase_i,   // Master engine phase
  input wire mst_sda_i,           // Level master engine sends
  output reg start_request_o,     // Start request to master engine
  output reg stop_request_o,      // Stop request to master engine
  output reg timer3_reload_o,     // Hold timer 3 in reload
  output reg ext_hold_o,          // Extended setup/hold enable
  output reg irq_o                // Interrupt, level
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ACKA = 3'd2;
  localparam S_RX = 3'd3;
  localparam S_ACKD = 3'd4;
  localparam S_TX = 3'd5;
  localparam S_TXAK = 3'd6;
  localparam S_WAIT = 3'd7;

  // Registers
  reg [7:0] cfg;
  reg start_request;
  reg stop_request;
  reg ack_lvl;
  reg si;
  reg [3:0] vec;
  reg arbl;
  reg [7:0] data;
  reg [6:0] own;
  reg [1:0] ists;
  reg [1:0] imsk;
  reg busy;

  // Bus side
  reg wr_pend;
  reg [9:0] wr_idx;
  reg [31:0] next_rdata;

  // Link side
  wire scl_s;
  wire sda_s;
  reg scl_d;
  reg sda_d;
  reg [2:0] st;
  reg [3:0] bitcnt;
  reg [7:0] sh;
  reg rw;
  reg txack;
  reg lost_pend;
  reg ev_si;
  reg ev_arb;
  reg ev_rx;
  reg [7:0] rx_byte;
  reg tick;
  wire bus_free;

  wire en = cfg[`SMBSC_CFG_EN];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
  wire mst_act = (mst_phase_i != `SMBSC_PH_NONE);
  wire arb_loss = mst_act & scl_rise & mst_sda_i & ~sda_s;
  wire addressed = (st != S_IDLE) && (st != S_ADDR);
  wire bus_acc = hsel_i & htrans_i[1] & hready_i;
  wire wr_ctrl = wr_pend && (wr_idx == `SMBSC_IDX_CTRL);
  wire wr_cfg = wr_pend && (wr_idx == `SMBSC_IDX_CFG);
  wire wr_data = wr_pend && (wr_idx == `SMBSC_IDX_DATA);
  wire wr_own = wr_pend && (wr_idx == `SMBSC_IDX_OWN);
  wire wr_ists = wr_pend && (wr_idx == `SMBSC_IDX_ISTS);
  wire wr_imsk = wr_pend && (wr_idx == `SMBSC_IDX_IMSK);

  smbsc_sync #(.RESET_VAL(1'b1)) u_sync_scl (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(scl_i),
    .q_o(scl_s)
  );

  smbsc_sync #(.RESET_VAL(1'b1)) u_sync_sda (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );

  smbsc_free_tmo u_free (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(en & cfg[`SMBSC_CFG_FTE]),
    .high_i(scl_s & sda_s),
    .tick_i(tick),
    .free_o(bus_free)
  );

  // Clock-source select, counted by the bus-free timeout
  always @* begin
    case (cfg[`SMBSC_CFG_CS_HI:`SMBSC_CFG_CS_LO])
      2'd0: tick = timer0_ovf_i;
      2'd1: tick = timer1_ovf_i;
      2'd2: tick = timer2h_ovf_i;
      default: tick = timer2l_ovf_i;
    endcase
  end

  // Read mux, sampled in the address phase
  always @* begin
    next_rdata = 32'h00000000;
    case (haddr_i[11:2])
      `SMBSC_IDX_CTRL: begin
        next_rdata[11:8] = vec;
        next_rdata[7] = mst_act;
        next_rdata[6] = (st == S_TX) || (st == S_TXAK);
        next_rdata[`SMBSC_CTL_STA] = start_request;
        next_rdata[`SMBSC_CTL_STO] = stop_request;
        next_rdata[3] = 1'b0;
        next_rdata[2] = arbl;
        next_rdata[`SMBSC_CTL_ACK] = ack_lvl;
        next_rdata[`SMBSC_CTL_SI] = si;
      end
      `SMBSC_IDX_CFG: begin
        next_rdata[7:0] = cfg;
        next_rdata[`SMBSC_CFG_BUSY] = busy;
      end
      `SMBSC_IDX_DATA: next_rdata[7:0] = data;
      `SMBSC_IDX_OWN: next_rdata[6:0] = own;
      `SMBSC_IDX_ISTS: next_rdata[1:0] = ists;
      `SMBSC_IDX_IMSK: next_rdata[1:0] = imsk;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // AHB-Lite slave and register file
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend <= 1'b0;
      wr_idx <= 10'h000;
      cfg <= `SMBSC_CFG_RESET;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      ack_lvl <= 1'b0;
      si <= 1'b0;
      data <= 8'h00;
      own <= 7'h00;
      ists <= 2'b00;
      imsk <= 2'b00;
      irq_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      wr_pend <= bus_acc & hwrite_i;
      if (bus_acc) begin
        wr_idx <= haddr_i[11:2];
        if (!hwrite_i)
          hrdata_o <= next_rdata;
      end
      if (wr_cfg) begin
        cfg <= hwdata_i[7:0];
      end
      if (wr_ctrl) begin
        start_request <= hwdata_i[`SMBSC_CTL_STA];
        stop_request <= hwdata_i[`SMBSC_CTL_STO];
        ack_lvl <= hwdata_i[`SMBSC_CTL_ACK];
      end
      // Hardware set wins over software clear
      if (ev_si)
        si <= 1'b1;
      else if (wr_ctrl)
        si <= hwdata_i[`SMBSC_CTL_SI];
      if (ev_rx)
        data <= rx_byte;
      else if (wr_data)
        data <= hwdata_i[7:0];
      if (wr_own)
        own <= hwdata_i[6:0];
      if (wr_imsk)
        imsk <= hwdata_i[1:0];
      ists[`SMBSC_IRQ_STATE] <= ev_si |
        (ists[`SMBSC_IRQ_STATE] & ~(wr_ists & hwdata_i[`SMBSC_IRQ_STATE]));
      ists[`SMBSC_IRQ_ARB] <= ev_arb |
        (ists[`SMBSC_IRQ_ARB] & ~(wr_ists & hwdata_i[`SMBSC_IRQ_ARB]));
      irq_o <= |(ists & imsk);
    end
  end

  // Line handling, busy and timer 3 control
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_o <= 1'b0;
      busy <= 1'b0;
      timer3_reload_o <= 1'b0;
      ext_hold_o <= 1'b0;
      start_request_o <= 1'b0;
      stop_request_o <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      // Hold clock low once it is low and a state awaits software
      scl_oe_o <= en & (si | ev_si) & (scl_oe_o | ~scl_s);
      if (!en)
        busy <= 1'b0;
      else if (start_det)
        busy <= 1'b1;
      else if (stop_det || bus_free)
        busy <= 1'b0;
      timer3_reload_o <= en & cfg[`SMBSC_CFG_TOE] & scl_s;
      ext_hold_o <= cfg[`SMBSC_CFG_EXTH];
      start_request_o <= start_request;
      stop_request_o <= stop_request;
    end
  end

  // Slave engine and arbitration reporting
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= S_IDLE;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      txack <= 1'b0;
      lost_pend <= 1'b0;
      sda_oe_o <= 1'b0;
      vec <= 4'h0;
      arbl <= 1'b0;
      ev_si <= 1'b0;
      ev_arb <= 1'b0;
      ev_rx <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      ev_si <= 1'b0;
      ev_arb <= 1'b0;
      ev_rx <= 1'b0;
      if (!en) begin
        st <= S_IDLE;
        sda_oe_o <= 1'b0;
        lost_pend <= 1'b0;
      end else if (start_det) begin
        st <= S_ADDR;
        bitcnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_det) begin
        st <= S_IDLE;
        sda_oe_o <= 1'b0;
        lost_pend <= 1'b0;
        if (mst_phase_i == `SMBSC_PH_DATA || mst_phase_i == `SMBSC_PH_RSTA) begin
          vec <= `SMBSC_VEC_STOP;
          arbl <= 1'b1;
          ev_si <= 1'b1;
          ev_arb <= 1'b1;
        end else if (addressed) begin
          vec <= `SMBSC_VEC_STOP;
          arbl <= 1'b0;
          ev_si <= 1'b1;
        end
      end else begin
        case (st)
          S_ADDR: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'd8) begin
              if (sh[7:1] == own && !cfg[`SMBSC_CFG_INH]) begin
                sda_oe_o <= 1'b1;
                rw <= sh[0];
                st <= S_ACKA;
              end else begin
                st <= S_IDLE;
                if (lost_pend) begin
                  vec <= `SMBSC_VEC_RXDATA;
                  arbl <= 1'b1;
                  ev_si <= 1'b1;
                  lost_pend <= 1'b0;
                end
              end
            end
          end
          S_ACKA: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              vec <= `SMBSC_VEC_ADDR;
              arbl <= lost_pend;
              lost_pend <= 1'b0;
              ev_si <= 1'b1;
              bitcnt <= 4'h0;
              st <= rw ? S_TX : S_RX;
            end
          end
          S_RX: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'd8) begin
              rx_byte <= sh;
              ev_rx <= 1'b1;
              sda_oe_o <= ack_lvl;
              st <= S_ACKD;
            end
          end
          S_ACKD: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              vec <= `SMBSC_VEC_RXDATA;
              arbl <= 1'b0;
              ev_si <= 1'b1;
              bitcnt <= 4'h0;
              st <= S_RX;
            end
          end
          S_TX: begin
            if (si) begin
              sh <= data;
              sda_oe_o <= ~data[7];
            end else if (scl_fall) begin
              if (bitcnt == 4'd7) begin
                sda_oe_o <= 1'b0;
                st <= S_TXAK;
              end else begin
                sda_oe_o <= ~sh[6];
                sh <= {sh[6:0], 1'b1};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          S_TXAK: begin
            if (scl_rise) begin
              txack <= ~sda_s;
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              if (txack) begin
                vec <= `SMBSC_VEC_TXDATA;
                arbl <= 1'b0;
                ev_si <= 1'b1;
                st <= S_TX;
              end else begin
                st <= S_WAIT;
              end
            end
          end
          S_IDLE, S_WAIT: begin
            sda_oe_o <= 1'b0;
          end
          default: st <= S_IDLE;
        endcase
        if (arb_loss) begin
          ev_arb <= 1'b1;
          case (mst_phase_i)
            `SMBSC_PH_DATA: begin
              if (st == S_ADDR) begin
                lost_pend <= 1'b1;
              end else begin
                vec <= `SMBSC_VEC_RXDATA;
                arbl <= 1'b1;
                ev_si <= 1'b1;
              end
            end
            `SMBSC_PH_RSTA: begin
              vec <= `SMBSC_VEC_ADDR;
              arbl <= 1'b1;
              ev_si <= 1'b1;
            end
            `SMBSC_PH_STOP: begin
              vec <= `SMBSC_VEC_STOP;
              arbl <= 1'b1;
              ev_si <= 1'b1;
            end
            default: ev_arb <= 1'b0;
          endcase
        end
      end
    end
  end
endmodule

// ### smbsc_defs.vh
`ifndef SMBSC_DEFS_VH
`define SMBSC_DEFS_VH

// Register indices; byte address is four times the index
`define SMBSC_IDX_CTRL 10'h0c0
`define SMBSC_IDX_CFG 10'h0c1
`define SMBSC_IDX_DATA 10'h0c2
`define SMBSC_IDX_OWN 10'h0c3
`define SMBSC_IDX_ISTS 10'h0c4
`define SMBSC_IDX_IMSK 10'h0c5

// Configuration field positions
`define SMBSC_CFG_EN 7
`define SMBSC_CFG_INH 6
`define SMBSC_CFG_BUSY 5
`define SMBSC_CFG_EXTH 4
`define SMBSC_CFG_TOE 3
`define SMBSC_CFG_FTE 2
`define SMBSC_CFG_CS_HI 1
`define SMBSC_CFG_CS_LO 0
`define SMBSC_CFG_RESET 8'h00

// Control field positions
`define SMBSC_CTL_STA 5
`define SMBSC_CTL_STO 4
`define SMBSC_CTL_ACK 1
`define SMBSC_CTL_SI 0

// Status vectors
`define SMBSC_VEC_RXDATA 4'h0
`define SMBSC_VEC_STOP 4'h1
`define SMBSC_VEC_ADDR 4'h2
`define SMBSC_VEC_TXDATA 4'h4

// Master engine phases
`define SMBSC_PH_NONE 2'd0
`define SMBSC_PH_DATA 2'd1
`define SMBSC_PH_RSTA 2'd2
`define SMBSC_PH_STOP 2'd3

// Bus-free limit in clock-source periods
`define SMBSC_FREE_PERIODS 4'd10

// Interrupt status bits
`define SMBSC_IRQ_STATE 0
`define SMBSC_IRQ_ARB 1

`endif

// ### smbsc_sync.v
`timescale 1ns/1ps
module smbsc_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk_i,    // System clock
  input wire reset_i,  // Async reset, active high
  input wire d_i,      // Asynchronous level
  output reg q_o       // Synchronised level
);
  reg meta;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ### smbsc_free_tmo.v
`timescale 1ns/1ps
`include "smbsc_defs.vh"
module smbsc_free_tmo (
  input wire clk_i,     // System clock
  input wire reset_i,   // Async reset, active high
  input wire enable_i,  // Free-timeout detection on
  input wire high_i,    // Both lines high
  input wire tick_i,    // Selected clock-source overflow
  output reg free_o     // One-cycle pulse: bus free
);
  reg [3:0] cnt;
  reg fired;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 4'h0;
      fired <= 1'b0;
      free_o <= 1'b0;
    end else begin
      free_o <= 1'b0;
      if (!enable_i || !high_i) begin
        cnt <= 4'h0;
        fired <= 1'b0;
      end else if (tick_i && !fired) begin
        // More than the limit: fires on the period after it
        if (cnt == `SMBSC_FREE_PERIODS) begin
          free_o <= 1'b1;
          fired <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// ### smbsc_checker.sv
`timescale 1ns/1ps
`include "smbsc_defs.vh"
module smbsc_checker (
  input wire clk_i,            // System clock
  input wire reset_i,          // Async reset
  input wire hsel_i,           // AHB select
  input wire [31:0] haddr_i,   // AHB address
  input wire [1:0] htrans_i,   // AHB transfer type
  input wire hwrite_i,         // AHB write
  input wire [31:0] hwdata_i,  // AHB write data
  input wire hready_i,         // AHB ready
  input wire scl_i,            // Clock line level
  input wire scl_o,            // Clock drive value
  input wire scl_oe_o,         // Clock pulled low
  input wire sda_o,            // Data drive value
  input wire sda_oe_o,         // Data pulled low
  input wire start_request_o,  // Start request
  input wire timer3_reload_o,  // Timer 3 reload
  input wire irq_o             // Interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire take = hsel_i && htrans_i[1] && hready_i && hwrite_i;
  reg cfg_wr;
  reg ctl_wr;
  reg [2:0] ctl_hist;
  reg [7:0] cfg_q;
  // Shadow of configuration writes and recent control writes
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_wr <= 1'b0;
      ctl_wr <= 1'b0;
      ctl_hist <= 3'h0;
      cfg_q <= 8'h00;
    end else begin
      cfg_wr <= take && haddr_i[11:2] == `SMBSC_IDX_CFG;
      ctl_wr <= take && haddr_i[11:2] == `SMBSC_IDX_CTRL;
      ctl_hist <= {ctl_hist[1:0], ctl_wr};
      if (cfg_wr) begin
        cfg_q <= hwdata_i[7:0];
      end
    end
  end
  reload_low_a: assert property ((!scl_i) [*4] |-> !timer3_reload_o)
    else $error("timer 3 reload while clock low");
  reload_off_a: assert property ((!cfg_q[3]) [*2] |-> !timer3_reload_o)
    else $error("timer 3 reload with timeout detection off");
  off_quiet_a: assert property ((!cfg_q[7]) [*4] |-> !sda_oe_o && !scl_oe_o)
    else $error("lines driven while disabled");
  inhibit_ack_a: assert property ($rose(sda_oe_o) |-> !cfg_q[6])
    else $error("slave drive while inhibited");
  data_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
  stretch_hold_a: assert property (scl_oe_o && !ctl_wr && ctl_hist == 3'h0 |=> scl_oe_o)
    else $error("clock stretch released without control write");
  start_copy_a: assert property (ctl_wr |-> ##2 start_request_o == $past(hwdata_i[5], 2))
    else $error("start request does not follow control write");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  cover property ($rose(scl_oe_o));
  cover property ($rose(sda_oe_o));
  cover property ($rose(irq_o));
  cover property ($rose(timer3_reload_o));
endmodule

bind smbsc_top smbsc_checker i_chk (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .start_request_o(start_request_o),
  .timer3_reload_o(timer3_reload_o), .irq_o(irq_o));

// ### smbsc_master_model.sv
`timescale 1ns/1ps
module smbsc_master_model (
  input wire scl_i,        // Clock line level
  input wire sda_i,        // Data line level
  output logic scl_low_o,  // Pull clock low
  output logic sda_low_o   // Pull data low
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic start();
    sda_low_o = 1'b1;
    #80 scl_low_o = 1'b1;
    #40;
  endtask
  // Honours stretching by waiting for the released clock to rise
  task automatic clk_bit(input logic b, output logic r);
    sda_low_o = !b;
    #40 scl_low_o = 1'b0;
    wait (scl_i === 1'b1);
    #40 r = sda_i;
    #40 scl_low_o = 1'b1;
    #40;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(1'b0, r);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    #40 scl_low_o = 1'b0;
    wait (scl_i === 1'b1);
    #80 sda_low_o = 1'b0;
    #80;
  endtask
  // Both lines released without a stop
  task automatic park();
    sda_low_o = 1'b0;
    #40 scl_low_o = 1'b0;
    #80;
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
`include "smbsc_defs.vh"
module tb;
  logic clk_i;
  logic reset_i;
  logic hsel, hwrite, hready, hresp, ack;
  logic [1:0] htrans;
  logic [1:0] phase;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] tmr;
  logic [7:0] byt;
  logic msda, scl_o, scl_oe, sda_o, sda_oe, scl_low, sda_low, sreq, streq, reload, exth, irq;
  wire scl = !(scl_oe || scl_low);
  wire sda = !(sda_oe || sda_low);
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  smbsc_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .timer0_ovf_i(tmr[0]), .timer1_ovf_i(tmr[1]),
    .timer2h_ovf_i(tmr[2]), .timer2l_ovf_i(tmr[3]), .mst_phase_i(phase),
    .mst_sda_i(msda), .start_request_o(sreq), .stop_request_o(streq),
    .timer3_reload_o(reload), .ext_hold_o(exth), .irq_o(irq));
  smbsc_master_model i_mst (.scl_i(scl), .sda_i(sda), .scl_low_o(scl_low),
    .sda_low_o(sda_low));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic ahb(input logic w, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, idx, 2'b00};
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, idx, 32'h0, r);
    check(r & m, e);
    check(hresp, 1'b0);
  endtask

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check(irq, v);
  endtask

  // Answer the reported state, then clear the interrupt status
  task automatic ack_next(input logic [31:0] ctl);
    wr(`SMBSC_IDX_CTRL, ctl);
    wr(`SMBSC_IDX_ISTS, 32'h3);
    wait_irq(1'b0);
  endtask

  task automatic tick(input logic [3:0] m);
    @(posedge clk_i);
    tmr <= m;
    @(posedge clk_i);
    tmr <= 4'h0;
  endtask

  initial begin
    reset_i = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, tmr, phase, msda} = '0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd_chk(`SMBSC_IDX_CFG, 32'hffffffff, 32'h0);
    rd_chk(10'h0c6, 32'hffffffff, 32'h0);
    wr(`SMBSC_IDX_CFG, 32'h20);
    rd_chk(`SMBSC_IDX_CFG, 32'hffffffff, 32'h0);
    wr(`SMBSC_IDX_OWN, 32'h2a);
    for (int i = 0; i < 2; i++) begin
      wr(`SMBSC_IDX_CFG, i ? 32'hc0 : 32'h00);
      i_mst.start();
      i_mst.tx(8'h54, ack);
      check(ack, 1'b0);
      i_mst.stop();
    end
    rd_chk(`SMBSC_IDX_ISTS, 32'h3, 32'h0);
    $display("test quiet done");
    wr(`SMBSC_IDX_IMSK, 32'h3);
    wr(`SMBSC_IDX_CFG, 32'h80);
    i_mst.start();
    i_mst.tx(8'h54, ack);
    check(ack, 1'b1);
    wait_irq(1'b1);
    wr(`SMBSC_IDX_IMSK, 32'h0);
    wait_irq(1'b0);
    wr(`SMBSC_IDX_IMSK, 32'h3);
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h201);
    rd_chk(`SMBSC_IDX_CFG, 32'hff, 32'ha0);
    ack_next(32'h2);
    i_mst.tx(8'hc5, ack);
    check(ack, 1'b1);
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h001);
    rd_chk(`SMBSC_IDX_DATA, 32'hff, 32'hc5);
    ack_next(32'h0);
    i_mst.tx(8'h3c, ack);
    check(ack, 1'b0);
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h001);
    rd_chk(`SMBSC_IDX_DATA, 32'hff, 32'h3c);
    ack_next(32'h10);
    check(streq, 1'b1);
    i_mst.stop();
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h101);
    rd_chk(`SMBSC_IDX_CFG, 32'hff, 32'h80);
    ack_next(32'h0);
    check(streq, 1'b0);
    $display("test slave write done");
    i_mst.start();
    i_mst.tx(8'h55, ack);
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h201);
    wr(`SMBSC_IDX_DATA, 32'h96);
    ack_next(32'h0);
    i_mst.rx(byt);
    check(byt, 8'h96);
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h401);
    wr(`SMBSC_IDX_DATA, 32'hff);
    ack_next(32'h0);
    i_mst.stop();
    wait_irq(1'b1);
    ack_next(32'h0);
    $display("test slave read done");
    i_mst.start();
    i_mst.tx(8'h22, ack);
    for (int p = 1; p < 4; p++) begin
      @(posedge clk_i);
      phase <= p[1:0];
      msda <= 1'b1;
      i_mst.clk_bit(1'b0, ack);
      wait_irq(1'b1);
      rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, {22'h0, p == 2, p == 3, 8'h05});
      rd_chk(`SMBSC_IDX_ISTS, 32'h3, 32'h3);
      @(posedge clk_i);
      phase <= 2'd0;
      msda <= 1'b0;
      ack_next(32'h20);
      check(sreq, 1'b1);
    end
    wr(`SMBSC_IDX_CTRL, 32'h0);
    i_mst.stop();
    // Lose on the first address bit, then get addressed as slave
    i_mst.start();
    @(posedge clk_i);
    phase <= 2'd1;
    msda <= 1'b1;
    i_mst.clk_bit(1'b0, ack);
    @(posedge clk_i);
    phase <= 2'd0;
    msda <= 1'b0;
    byt = 8'h54;
    for (int b = 6; b >= 0; b--) begin
      i_mst.clk_bit(byt[b], ack);
    end
    i_mst.clk_bit(1'b1, ack);
    check(ack, 1'b0);
    repeat (8) @(posedge clk_i);
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h205);
    ack_next(32'h20);
    check(sreq, 1'b1);
    // Stop seen while the master engine still sends
    @(posedge clk_i);
    phase <= 2'd1;
    i_mst.stop();
    wait_irq(1'b1);
    rd_chk(`SMBSC_IDX_CTRL, 32'hf0d, 32'h105);
    @(posedge clk_i);
    phase <= 2'd0;
    ack_next(32'h0);
    check(sreq, 1'b0);
    $display("test arbitration done");
    for (int k = 0; k < 4; k++) begin
      wr(`SMBSC_IDX_CFG, 32'h9c | k);
      i_mst.start();
      i_mst.park();
      repeat (12) tick(4'hf & ~(4'h1 << k));
      rd_chk(`SMBSC_IDX_CFG, 32'h20, 32'h20);
      check(reload, 1'b1);
      check(exth, 1'b1);
      repeat (10) tick(4'h1 << k);
      rd_chk(`SMBSC_IDX_CFG, 32'h20, 32'h20);
      tick(4'h1 << k);
      rd_chk(`SMBSC_IDX_CFG, 32'h20, 32'h0);
    end
    $display("test free timeout done");
    test_done();
  end
endmodule
